// [core/dmac_core.sv]
// dmac_core: core side hold logic and peripheral request pins.
// assumes the controller end on the same clock across dmac_link_if.
`timescale 1ns/1ps

module dmac_core
   import dmac_pkg::*;
(
   // clock and reset
   input  wire logic       CLK,
   input  wire logic       RST_B,
   // peripheral pins
   input  wire logic [3:0] PERIPH_REQ_N,
   output wire logic [3:0] PERIPH_ACK_N,
   // core side
   input  wire logic       PENDING_GATE,
   output wire logic       HOLD_ACTIVE,
   output wire logic [3:0] DMA_IRQ,
   // link to controller
   dmac_link_if.core       lnk
);

   // ==========================================================
   // state
   localparam dmac_core_st_t ST_RST = '{
      s1: 4'hf, s2: 4'hf, ack_n: 4'hf, default: '0};

   dmac_core_st_t st_r;
   dmac_core_st_t st_nxt;

   always_comb begin
      st_nxt = st_r;
      // pins pass two flops; pulses shorter than a cycle are lost
      st_nxt.s1 = PERIPH_REQ_N;
      st_nxt.s2 = st_r.s1;
      // buses released while requested, kept until withdrawn
      st_nxt.hold_ack = lnk.hold_req;
      st_nxt.gate = PENDING_GATE;
      st_nxt.ack_n = lnk.ack_n;
      st_nxt.irq = lnk.irq;
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign lnk.req_n     = st_r.s2;
   assign lnk.hold_ack  = st_r.hold_ack;
   assign lnk.pend_gate = st_r.gate;
   assign PERIPH_ACK_N  = st_r.ack_n;
   assign HOLD_ACTIVE   = st_r.hold_ack;
   assign DMA_IRQ       = st_r.irq;

endmodule : dmac_core

// [core/dmac_defs.svh]
// dmac_defs.svh: offsets, field positions and reset values of the
// four channel transfer controller.
// assumes inclusion by bare name from the package and the test bench.
`ifndef DMAC_DEFS_SVH
`define DMAC_DEFS_SVH

// ==========================================================
// register word indices (byte address = 4 * index)
`define DMAC_IDX_GC       8'h40
`define DMAC_IDX_MS       8'h41
`define DMAC_IDX_AIC      8'h42
`define DMAC_IDX_CH_LAST  8'h0f
`define DMAC_CHR_IA       2'h0
`define DMAC_CHR_CA       2'h1
`define DMAC_CHR_IC       2'h2
`define DMAC_CHR_CC       2'h3

// ==========================================================
// reset values
`define DMAC_GC_RST       16'h0000
`define DMAC_MS_RST       16'h3333
`define DMAC_AIC_RST      16'h0000

// ==========================================================
// per channel fields, each channel owns one nibble
`define DMAC_FLD_STRIDE   4
`define DMAC_GC_BUS       0
`define DMAC_GC_DIR       2
`define DMAC_MS_MASK      0
`define DMAC_MS_SENS      1
`define DMAC_AIC_IE       0
`define DMAC_AIC_IP       1
`define DMAC_AIC_RELOAD   2
`define DMAC_AIC_STEP     3

// ==========================================================
// bus choice codes
`define DMAC_BUS_X        2'h0
`define DMAC_BUS_Y        2'h1
`define DMAC_BUS_I        2'h2

`endif

// [core/dmac_dev.sv]
// dmac_dev: four channel cycle stealing transfer controller.
// assumes a classic wishbone master and the core hold end on one clock.
// Overview of operation
// - four channels, each request, acknowledge, interrupt
// - transfers on I, X, Y; X with Y
// - single word three cycles, I adds one
// - n words take n plus two cycles
// - fixed priority, channel 0 highest
// - same bus requests merged into one transfer
// - hold request raised to start transfer
// - core acknowledges hold, holds until withdrawn
// - drop hold after transfer, then idle
// - request edge or level sensitive per channel
// - double buffering over 2N consecutive addresses
// - interrupt after predefined word count
// - interrupting channels edge sensitive, prioritised
// - request pins live only when serial inhibited
// - 16-bit initial and current address per channel
// - current address hold, step or reload
// - software loads both counts with N-1
// - current count decrements, reloads at zero
// - three 16-bit control registers
// - bus choice and direction fields per channel
// - mask and sensitivity bits per channel
// - interrupt enable and gated pending bit
//
// The implementer's own choices: the Wishbone register port and the register offsets.
`timescale 1ns/1ps

module dmac_dev
   import dmac_pkg::*;
(
   // clock and reset
   input  wire logic        CLK,
   input  wire logic        RST_B,
   // pin management
   input  wire logic        SERIAL_IO_INHIBIT,
   // wishbone slave
   input  wire logic        WB_CYC_I,
   input  wire logic        WB_STB_I,
   input  wire logic        WB_WE_I,
   input  wire logic [9:0]  WB_ADR_I,
   input  wire logic [3:0]  WB_SEL_I,
   input  wire logic [31:0] WB_DAT_I,
   output wire logic [31:0] WB_DAT_O,
   output wire logic        WB_ACK_O,
   // link to core
   dmac_link_if.dev         lnk
);

   // ==========================================================
   // helpers
   function automatic logic [3:0] dmac_first(input logic [3:0] v);
      logic [3:0] r;
      r = 4'h0;
      for (int k = 3; k >= 0; k--) begin
         if (v[k]) begin
            r = 4'h0;
            r[k] = 1'b1;
         end
      end
      return r;
   endfunction : dmac_first

   function automatic logic [15:0] dmac_lane(input logic [15:0] old,
                                             input logic [15:0] d,
                                             input logic [1:0]  sel);
      logic [15:0] r;
      r = old;
      if (sel[0]) begin
         r[7:0] = d[7:0];
      end
      if (sel[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction : dmac_lane

   // ==========================================================
   // state
   localparam dmac_dev_st_t ST_RST = '{
      fsm: DMAC_IDLE, gc: `DMAC_GC_RST, ms: `DMAC_MS_RST,
      aic: `DMAC_AIC_RST, ack_n: 4'hf, s1: 4'hf, s2: 4'hf, s3: 4'hf,
      default: '0};

   dmac_dev_st_t st_r;
   dmac_dev_st_t st_nxt;

   logic [7:0]  idx;
   logic        wr_go;
   logic [3:0]  fall;
   logic [3:0]  live;
   logic [3:0]  req_v;
   logic [3:0]  keep;
   logic [3:0]  on_x;
   logic [3:0]  on_y;
   logic [3:0]  on_i;
   logic [3:0]  fx;
   logic [3:0]  fy;
   logic [3:0]  fi;
   logic [3:0]  srv;
   logic [15:0] cc_nxt [4];
   logic [15:0] rdv;
   logic [1:0]  bsel;
   int          b;

   always_comb begin
      st_nxt = st_r;
      idx    = WB_ADR_I[9:2];
      b      = 0;
      bsel   = 2'h0;
      srv    = 4'h0;
      keep   = 4'h0;
      rdv    = 16'h0000;
      for (int c = 0; c < 4; c++) begin
         cc_nxt[c] = st_r.cc[c];
      end

      // ==========================================================
      // wishbone slave: ack one cycle after strobe, write at ack edge
      st_nxt.wb_ack = WB_CYC_I & WB_STB_I & ~st_r.wb_ack;
      wr_go = WB_CYC_I & WB_STB_I & WB_WE_I & st_r.wb_ack;
      if (idx <= `DMAC_IDX_CH_LAST) begin
         unique case (idx[1:0])
            `DMAC_CHR_IA: rdv = st_r.ia[idx[3:2]];
            `DMAC_CHR_CA: rdv = st_r.ca[idx[3:2]];
            `DMAC_CHR_IC: rdv = st_r.ic[idx[3:2]];
            `DMAC_CHR_CC: rdv = st_r.cc[idx[3:2]];
         endcase
      end else if (idx == `DMAC_IDX_GC) begin
         rdv = st_r.gc;
      end else if (idx == `DMAC_IDX_MS) begin
         rdv = st_r.ms;
      end else if (idx == `DMAC_IDX_AIC) begin
         rdv = st_r.aic;
      end
      st_nxt.wb_dat = {16'h0000, rdv};
      if (wr_go) begin
         if (idx <= `DMAC_IDX_CH_LAST) begin
            unique case (idx[1:0])
               `DMAC_CHR_IA: st_nxt.ia[idx[3:2]] =
                  dmac_lane(st_r.ia[idx[3:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
               `DMAC_CHR_CA: st_nxt.ca[idx[3:2]] =
                  dmac_lane(st_r.ca[idx[3:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
               `DMAC_CHR_IC: st_nxt.ic[idx[3:2]] =
                  dmac_lane(st_r.ic[idx[3:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
               `DMAC_CHR_CC: st_nxt.cc[idx[3:2]] =
                  dmac_lane(st_r.cc[idx[3:2]], WB_DAT_I[15:0], WB_SEL_I[1:0]);
            endcase
         end else if (idx == `DMAC_IDX_GC) begin
            st_nxt.gc = dmac_lane(st_r.gc, WB_DAT_I[15:0], WB_SEL_I[1:0]);
         end else if (idx == `DMAC_IDX_MS) begin
            st_nxt.ms = dmac_lane(st_r.ms, WB_DAT_I[15:0], WB_SEL_I[1:0]);
         end else if (idx == `DMAC_IDX_AIC) begin
            st_nxt.aic = dmac_lane(st_r.aic, WB_DAT_I[15:0], WB_SEL_I[1:0]);
         end
      end

      // ==========================================================
      // request pins: two flops, then edge or level
      st_nxt.s1 = lnk.req_n;
      st_nxt.s2 = st_r.s1;
      st_nxt.s3 = st_r.s2;
      fall = st_r.s3 & ~st_r.s2;
      for (int c = 0; c < 4; c++) begin
         b = c * `DMAC_FLD_STRIDE;
         live[c] = SERIAL_IO_INHIBIT &
                   ~st_r.ms[b + `DMAC_MS_MASK];
         req_v[c] = live[c] & (st_r.ms[b + `DMAC_MS_SENS] ?
                    st_r.edge_pend[c] : ~st_r.s2[c]);
         bsel = st_r.gc[b + `DMAC_GC_BUS +: 2];
         on_y[c] = (bsel == `DMAC_BUS_Y);
         on_i[c] = (bsel == `DMAC_BUS_I);
         on_x[c] = ~on_y[c] & ~on_i[c];
      end
      fx = dmac_first(st_r.rem & on_x);
      fy = dmac_first(st_r.rem & on_y);
      fi = dmac_first(st_r.rem & on_i);

      // ==========================================================
      // sequencer
      unique case (st_r.fsm)
         DMAC_IDLE: begin
            if (|req_v) begin
               st_nxt.hold_req = 1'b1;
               st_nxt.fsm = DMAC_HOLD;
            end
         end
         DMAC_HOLD: begin
            if (lnk.hold_ack) begin
               st_nxt.rem = req_v;
               st_nxt.fsm = DMAC_REL;
            end
         end
         DMAC_REL, DMAC_DATA: begin
            if (st_r.i_extra) begin
               st_nxt.i_extra = 1'b0;
            end else begin
               // X and Y words go out side by side, I waits alone
               srv = (|(fx | fy)) ? (fx | fy) : fi;
               st_nxt.i_extra = ~(|(fx | fy)) & (|fi);
               st_nxt.x_vld = |fx;
               st_nxt.y_vld = |fy;
               st_nxt.i_vld = ~(|(fx | fy)) & (|fi);
               st_nxt.ack_n = ~srv;
               if (srv == 4'h0) begin
                  st_nxt.hold_req = 1'b0;
                  st_nxt.fsm = DMAC_FIN;
               end else begin
                  st_nxt.fsm = DMAC_DATA;
               end
            end
         end
         DMAC_FIN: begin
            st_nxt.fsm = DMAC_IDLE;
         end
         default: begin
            st_nxt.fsm = DMAC_IDLE;
         end
      endcase

      // ==========================================================
      // per word update of the serviced channels
      for (int c = 0; c < 4; c++) begin
         b = c * `DMAC_FLD_STRIDE;
         if (srv[c]) begin
            if (fx[c]) begin
               st_nxt.x_addr = st_r.ca[c];
               st_nxt.x_rd = st_r.gc[b + `DMAC_GC_DIR];
            end
            if (fy[c]) begin
               st_nxt.y_addr = st_r.ca[c];
               st_nxt.y_rd = st_r.gc[b + `DMAC_GC_DIR];
            end
            if (on_i[c]) begin
               st_nxt.i_addr = st_r.ca[c];
               st_nxt.i_rd = st_r.gc[b + `DMAC_GC_DIR];
            end
            // reload at zero closes one full pass of a ring buffer
            cc_nxt[c] = (st_r.cc[c] == 16'h0000) ? st_r.ic[c] :
                        st_r.cc[c] - 16'h0001;
            st_nxt.cc[c] = cc_nxt[c];
            if (st_r.aic[b + `DMAC_AIC_STEP]) begin
               st_nxt.ca[c] = (st_r.aic[b + `DMAC_AIC_RELOAD] &&
                              st_r.cc[c] == 16'h0000) ?
                              st_r.ia[c] : st_r.ca[c] + 16'h0001;
            end
            if (cc_nxt[c] == 16'h0000) begin
               st_nxt.aic[b + `DMAC_AIC_IP] = 1'b1;
            end
            keep[c] = live[c] & ~st_r.ms[b + `DMAC_MS_SENS] &
                      ~st_r.s2[c] & (cc_nxt[c] != 16'h0000);
         end
         st_nxt.irq[c] = st_nxt.aic[b + `DMAC_AIC_IP] &
                         st_r.aic[b + `DMAC_AIC_IE] &
                         lnk.pend_gate;
         // an edge in the service cycle survives the clear
         st_nxt.edge_pend[c] = (st_r.edge_pend[c] & ~srv[c]) |
                               (fall[c] & live[c] &
                                st_r.ms[b + `DMAC_MS_SENS]);
      end
      if (|srv) begin
         st_nxt.rem = (st_r.rem & ~srv) | keep;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         st_r <= ST_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   // ==========================================================
   // outputs
   assign WB_DAT_O     = st_r.wb_dat;
   assign WB_ACK_O     = st_r.wb_ack;
   assign lnk.hold_req = st_r.hold_req;
   assign lnk.ack_n    = st_r.ack_n;
   assign lnk.irq      = st_r.irq;
   assign lnk.x_addr   = st_r.x_addr;
   assign lnk.y_addr   = st_r.y_addr;
   assign lnk.i_addr   = st_r.i_addr;
   assign lnk.x_vld    = st_r.x_vld;
   assign lnk.y_vld    = st_r.y_vld;
   assign lnk.i_vld    = st_r.i_vld;
   assign lnk.x_rd     = st_r.x_rd;
   assign lnk.y_rd     = st_r.y_rd;
   assign lnk.i_rd     = st_r.i_rd;

endmodule : dmac_dev

// [core/dmac_link_if.sv]
// dmac_link_if: wires between the transfer controller and the core.
// assumes both ends run on the same clock.
`timescale 1ns/1ps

interface dmac_link_if;
   logic        hold_req;
   logic        hold_ack;
   logic [3:0]  req_n;
   logic [3:0]  ack_n;
   logic [3:0]  irq;
   logic        pend_gate;
   logic [15:0] x_addr;
   logic [15:0] y_addr;
   logic [15:0] i_addr;
   logic        x_vld;
   logic        y_vld;
   logic        i_vld;
   logic        x_rd;
   logic        y_rd;
   logic        i_rd;

   modport dev (
      output hold_req, ack_n, irq, x_addr, y_addr, i_addr,
             x_vld, y_vld, i_vld, x_rd, y_rd, i_rd,
      input  hold_ack, req_n, pend_gate
   );
   modport core (
      input  hold_req, ack_n, irq, x_addr, y_addr, i_addr,
             x_vld, y_vld, i_vld, x_rd, y_rd, i_rd,
      output hold_ack, req_n, pend_gate
   );
endinterface : dmac_link_if

// [core/dmac_pkg.sv]
// dmac_pkg: types shared by both ends of the transfer controller link.
// assumes dmac_defs.svh on the include path.
`include "dmac_defs.svh"

package dmac_pkg;

   // ==========================================================
   // sequencer states
   typedef enum logic [2:0] {
      DMAC_IDLE = 3'b000,
      DMAC_HOLD = 3'b001,
      DMAC_REL  = 3'b010,
      DMAC_DATA = 3'b011,
      DMAC_FIN  = 3'b100
   } dmac_fsm_t;

   typedef logic [3:0][15:0] dmac_bank_t;

   // ==========================================================
   // controller state
   typedef struct packed {
      dmac_fsm_t   fsm;
      logic [3:0]  rem;
      logic        i_extra;
      logic [3:0]  s1;
      logic [3:0]  s2;
      logic [3:0]  s3;
      logic [3:0]  edge_pend;
      logic [15:0] gc;
      logic [15:0] ms;
      logic [15:0] aic;
      dmac_bank_t  ia;
      dmac_bank_t  ca;
      dmac_bank_t  ic;
      dmac_bank_t  cc;
      logic        hold_req;
      logic [3:0]  ack_n;
      logic [3:0]  irq;
      logic [15:0] x_addr;
      logic [15:0] y_addr;
      logic [15:0] i_addr;
      logic        x_vld;
      logic        y_vld;
      logic        i_vld;
      logic        x_rd;
      logic        y_rd;
      logic        i_rd;
      logic        wb_ack;
      logic [31:0] wb_dat;
   } dmac_dev_st_t;

   // ==========================================================
   // core hold end state
   typedef struct packed {
      logic [3:0] s1;
      logic [3:0] s2;
      logic       hold_ack;
      logic       gate;
      logic [3:0] ack_n;
      logic [3:0] irq;
   } dmac_core_st_t;

endpackage : dmac_pkg

// [test/dmac_properties.sv]
// dmac_properties: timing checks on the controller to core link.
// assumes one clock for both ends and a sync active low reset.
`timescale 1ns/1ps

module dmac_properties (
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_B,
   // hold handshake
   input wire logic        hold_req,
   input wire logic        hold_ack,
   // channel lines
   input wire logic [3:0]  ack_n,
   input wire logic [3:0]  irq,
   input wire logic        pend_gate,
   // bus cycles
   input wire logic [15:0] i_addr,
   input wire logic        x_vld,
   input wire logic        y_vld,
   input wire logic        i_vld
);
   // ==========================================================
   // link relations
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_B);

   a_hold_answer: assert property ($rose(hold_req) |=> hold_ack)
      else $error("hold not acknowledged");
   a_hold_drop: assert property ($fell(hold_req) |->
      hold_ack && ack_n == 4'hf ##1 !hold_ack)
      else $error("hold release out of order");
   a_release_gap: assert property ($rose(hold_ack) |->
      (hold_req && ack_n == 4'hf && !x_vld && !y_vld && !i_vld)[*2])
      else $error("data cycle without release cycle");
   a_data_held: assert property (x_vld || y_vld || i_vld |->
      hold_req && hold_ack)
      else $error("data cycle outside hold");
   a_ack_data: assert property (ack_n != 4'hf |->
      x_vld || y_vld || i_vld)
      else $error("acknowledge without data cycle");
   a_bus_pairing: assert property (x_vld || y_vld || i_vld |->
      $countones(~ack_n) == int'(x_vld) + int'(y_vld) + int'(i_vld))
      else $error("acknowledge count differs from busy buses");
   a_i_alone: assert property (i_vld |-> !x_vld && !y_vld)
      else $error("instruction transfer overlaps data buses");
   a_i_word_long: assert property ($rose(i_vld) |=>
      i_vld && $stable(i_addr) && $stable(ack_n))
      else $error("instruction word shorter than two cycles");
   a_irq_gated: assert property (irq != 4'h0 |-> $past(pend_gate))
      else $error("interrupt while gate low");
   a_hold_bound: assert property ($rose(hold_req) |->
      ##[4:40] !hold_req)
      else $error("hold request not withdrawn");

endmodule : dmac_properties

// [test/dmac_test.sv]
// dmac_test: self-checking bench joining controller and core ends.
// assumes the design package, defines header and link interface.
`timescale 1ns/1ps
`include "dmac_defs.svh"

module dmac_test
   import dmac_pkg::*;
   ;
   // ==========================================================
   // stimulus and observation
   logic        clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        inhibit = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [9:0]  adr = 10'h000;
   logic [31:0] wdat = 32'h0;
   logic [3:0]  sel = 4'h3;
   logic [3:0]  lanes = 4'h3;
   logic [31:0] rdat;
   logic        ack;
   logic [3:0]  preq_n = 4'hf;
   logic [3:0]  pack_n;
   logic [3:0]  irq_o;
   logic        gate = 1'b0;
   logic        hold_act;
   logic [31:0] seed = 32'h42dc30a2;
   logic [15:0] gc_cfg = 16'h0;
   logic [15:0] aic_cfg = 16'h0;
   logic [15:0] q;
   logic [15:0] m_ia [4];
   logic [15:0] m_ca [4];
   logic [15:0] m_ic [4];
   logic [15:0] m_cc [4];
   logic [3:0]  m_pend;
   int          words [4];
   int          slot [4];
   int          es [4];
   int          len;
   int          n_fail = 0;
   int          num_checks = 0;
   int          cycles = 0;

   dmac_link_if lnk ();
   dmac_dev i_dmac_dev (
      .CLK               (clk),
      .RST_B             (rst_b),
      .SERIAL_IO_INHIBIT (inhibit),
      .WB_CYC_I          (cyc),
      .WB_STB_I          (stb),
      .WB_WE_I           (we),
      .WB_ADR_I          (adr),
      .WB_SEL_I          (sel),
      .WB_DAT_I          (wdat),
      .WB_DAT_O          (rdat),
      .WB_ACK_O          (ack),
      .lnk               (lnk)
   );
   dmac_core i_dmac_core (
      .CLK          (clk),
      .RST_B        (rst_b),
      .PERIPH_REQ_N (preq_n),
      .PERIPH_ACK_N (pack_n),
      .PENDING_GATE (gate),
      .HOLD_ACTIVE  (hold_act),
      .DMA_IRQ      (irq_o),
      .lnk          (lnk)
   );
   dmac_properties i_dmac_properties (
      .CLK       (clk),
      .RST_B     (rst_b),
      .hold_req  (lnk.hold_req),
      .hold_ack  (lnk.hold_ack),
      .ack_n     (lnk.ack_n),
      .irq       (lnk.irq),
      .pend_gate (lnk.pend_gate),
      .i_addr    (lnk.i_addr),
      .x_vld     (lnk.x_vld),
      .y_vld     (lnk.y_vld),
      .i_vld     (lnk.i_vld)
   );

   always #2 clk = ~clk;

   // a hang counts as a failure
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         n_fail++;
         complete_run();
      end
   end

   // ==========================================================
   // helpers
   task automatic complete_run();
      $display("checks %0d failures %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : complete_run

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check

   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd

   // one classic cycle; read data lands in q
   task automatic wb(input logic w, input logic [7:0] i, input logic [15:0] d);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {i, 2'b00};
      sel <= lanes;
      wdat <= {16'h0, d};
      do @(posedge clk); while (ack !== 1'b1);
      q = rdat[15:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask : wb

   // address of the next word, then step the channel's counters
   function automatic logic [15:0] model_word(input int c);
      logic [15:0] a;
      a = m_ca[c];
      if (aic_cfg[4*c+3]) begin
         m_ca[c] = aic_cfg[4*c+2] && m_cc[c] == 16'h0 ?
                   m_ia[c] : a + 16'h1;
      end
      m_cc[c] = m_cc[c] == 16'h0 ? m_ic[c] : m_cc[c] - 16'h1;
      if (m_cc[c] == 16'h0) m_pend[c] = 1'b1;
      return a;
   endfunction : model_word

   // expected slots in es, returns hold acknowledge length
   function automatic int plan(input logic [3:0] m);
      int n [3];
      int d;
      n = '{0, 0, 0};
      for (int c = 0; c < 4; c++) begin
         if (m[c]) begin
            es[c] = 3 + n[gc_cfg[4*c +: 2]];
            n[gc_cfg[4*c +: 2]]++;
         end
      end
      d = n[0] > n[1] ? n[0] : n[1];
      for (int c = 0; c < 4; c++) begin
         if (m[c] && gc_cfg[4*c +: 2] == 2'h2) es[c] = es[c] * 2 + d - 3;
      end
      return d + 2 * n[2] + 3;
   endfunction : plan

   task automatic xfer(input logic [3:0] m, input logic lvl);
      logic [15:0] a;
      logic [1:0]  b;
      logic        r;
      len = 0;
      words = '{default: 0};
      slot = '{default: 0};
      preq_n <= ~m;
      repeat (2) @(posedge clk);
      if (!lvl) preq_n <= 4'hf;
      do @(posedge clk); while (lnk.hold_ack !== 1'b1);
      while (lnk.hold_ack === 1'b1) begin
         len++;
         for (int c = 0; c < 4; c++) begin
            b = gc_cfg[4*c +: 2];
            a = b == 2'h1 ? lnk.y_addr : b == 2'h2 ? lnk.i_addr : lnk.x_addr;
            r = b == 2'h1 ? lnk.y_rd : b == 2'h2 ? lnk.i_rd : lnk.x_rd;
            if (lnk.ack_n[c] === 1'b0) begin
               if (words[c] == 0) slot[c] = len;
               if (b != 2'h2 || words[c] % 2 == 0) begin
                  check({r, a}, {gc_cfg[4*c+2], model_word(c)});
               end
               words[c]++;
            end
         end
         @(posedge clk);
      end
   endtask : xfer

   task automatic quiet(input logic [3:0] m);
      logic seen;
      seen = 1'b0;
      preq_n <= ~m;
      repeat (2) @(posedge clk);
      preq_n <= 4'hf;
      repeat (30) begin
         @(posedge clk);
         seen = seen | lnk.hold_req;
      end
      check(seen, 1'b0);
   endtask : quiet

   // ==========================================================
   // main sequence
   initial begin
      logic [31:0] v;
      logic [3:0]  m;
      logic [1:0]  b;
      int          el;
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      @(posedge clk);
      for (int i = 0; i < 16; i++) begin
         v = rnd();
         wb(1'b0, 8'(i), 16'h0);
         check(q, 16'h0);
         wb(1'b1, 8'(i), v[15:0]);
         wb(1'b0, 8'(i), 16'h0);
         check(q, v[15:0]);
      end
      // only the upper lane of a write lands
      wb(1'b1, 8'h00, 16'h0000);
      lanes = 4'h2;
      wb(1'b1, 8'h00, 16'hffff);
      lanes = 4'h3;
      wb(1'b0, 8'h00, 16'h0);
      check(q, 16'hff00);
      wb(1'b0, `DMAC_IDX_GC, 16'h0);
      check(q, 16'h0000);
      wb(1'b0, `DMAC_IDX_MS, 16'h0);
      check(q, 16'h3333);
      wb(1'b0, `DMAC_IDX_AIC, 16'h0);
      check(q, 16'h0000);
      wb(1'b1, 8'h20, 16'hbeef);
      wb(1'b0, 8'h20, 16'h0);
      check(q, 16'h0);
      quiet(4'hf);
      // all channels edge sensitive; request pins dead while serial not inhibited
      wb(1'b1, `DMAC_IDX_MS, 16'h2222);
      inhibit <= 1'b0;
      quiet(4'hf);
      inhibit <= 1'b1;
      for (int r = 0; r < 6; r++) begin
         v = rnd();
         gate <= v[31];
         for (int c = 0; c < 4; c++) begin
            v = rnd();
            b = r == 0 ? 2'(c / 2 + c / 3) : v[20:19] % 2'h3;
            m_ia[c] = v[15:0];
            m_ca[c] = v[15:0];
            m_ic[c] = {14'h0, v[17:16]};
            m_cc[c] = {14'h0, v[17:16]};
            gc_cfg[4*c +: 4] = {1'b0, v[21], b};
            aic_cfg[4*c +: 4] = {v[24], v[22], 1'b0, v[23]};
            wb(1'b1, 8'(4*c), m_ia[c]);
            wb(1'b1, 8'(4*c+1), m_ia[c]);
            wb(1'b1, 8'(4*c+2), m_ic[c]);
            wb(1'b1, 8'(4*c+3), m_ic[c]);
         end
         wb(1'b1, `DMAC_IDX_GC, gc_cfg);
         wb(1'b1, `DMAC_IDX_AIC, aic_cfg);
         m_pend = 4'h0;
         for (int e = 0; e < 3; e++) begin
            v = rnd();
            m = r == 0 && e == 0 ? 4'hf : (v[3:0] == 4'h0 ? 4'h8 : v[3:0]);
            el = plan(m);
            xfer(m, 1'b0);
            check(len, el);
            for (int c = 0; c < 4; c++) begin
               el = m[c] ? 1 + int'(gc_cfg[4*c +: 2] == 2'h2) : 0;
               check(words[c], el);
               if (m[c]) check(slot[c], es[c]);
            end
            repeat (4) @(posedge clk);
            m = {aic_cfg[12], aic_cfg[8], aic_cfg[4], aic_cfg[0]};
            check({hold_act, pack_n, irq_o},
                  {1'b0, 4'hf, m_pend & m & {4{gate}}});
         end
         wb(1'b0, `DMAC_IDX_AIC, 16'h0);
         check(q, aic_cfg | {2'h0, m_pend[3], 3'h0, m_pend[2],
                             3'h0, m_pend[1], 3'h0, m_pend[0], 1'b0});
      end
      // level request on channel 3, the lowest priority, moves a block in one hold
      v = rnd();
      m_ia[3] = v[15:0];
      m_ca[3] = v[15:0];
      m_ic[3] = 16'h3;
      m_cc[3] = 16'h3;
      gc_cfg = 16'h0000;
      aic_cfg = 16'h8000;
      for (int k = 0; k < 4; k++) begin
         wb(1'b1, 8'(12 + k), k < 2 ? v[15:0] : 16'h3);
      end
      wb(1'b1, `DMAC_IDX_GC, gc_cfg);
      wb(1'b1, `DMAC_IDX_AIC, aic_cfg);
      wb(1'b1, `DMAC_IDX_MS, 16'h0333);
      xfer(4'h8, 1'b1);
      inhibit <= 1'b0;
      preq_n <= 4'hf;
      check(words[3], int'(m_ic[3]));
      check(len, int'(m_ic[3]) + 3);
      repeat (20) @(posedge clk);
      complete_run();
   end

endmodule : dmac_test
